// ---- hdl/ccr_control_one.sv ----
// Control-one register with its decoded mode outputs and comparator debounce
`timescale 1ns/1ps
module ccr_control_one
    import ccr_pkg::*;
#(
    parameter logic [31:0] DEB2_CYC = CCR_DEB2_CYC,
    parameter logic [31:0] DEB3_CYC = CCR_DEB3_CYC
) (
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic        WR_EN,
    input  wire logic        RD_EN,
    input  wire logic [7:0]  ADDR,
    input  wire logic [15:0] WDATA,
    input  wire logic        BATTERY_ABSENT_PIN,
    input  wire logic        ADAPTER_PRESENT,
    input  wire logic        SINGLE_CELL,
    input  wire logic        BATTERY_BELOW_SETPOINT,
    input  wire logic        COMPARATOR_RAW,
    output logic [15:0]      RDATA,
    output logic             RVALID,
    output logic             LEARN_ACTIVE,
    output logic             REVERSE_POWER_EN,
    output logic             AUDIO_FILTER_EN,
    output logic [9:0]       SWITCH_FREQ_KHZ,
    output logic             BOOST_ASSIST_EN,
    output logic             CURRENT_MONITORS_EN,
    output logic             MONITOR_SELECT_BATTERY,
    output logic             SYSTEM_POWER_MONITOR_EN,
    output logic             RAIL_SWITCHING_EN,
    output logic             BATTERY_FET_GATE_FORCE,
    output logic [9:0]       THROTTLE_THRESHOLD,
    output logic             COMPARATOR_ASSERTED
);
    logic [15:0] ctrl_q, ctrl_d;
    logic [15:0] rdata_q, rdata_d;
    logic        rvalid_q, rvalid_d;
    logic [2:0]  bat_s_q, bat_s_d;
    logic [2:0]  adp_s_q, adp_s_d;
    logic [2:0]  one_s_q, one_s_d;
    logic [2:0]  low_s_q, low_s_d;
    logic [2:0]  cmp_s_q, cmp_s_d;
    logic        learn_q, learn_d;
    logic [31:0] deb_cnt_q, deb_cnt_d;
    logic        cmp_q, cmp_d;
    logic        rev_q, rev_d, aud_q, aud_d, boost_q, boost_d, mon_q, mon_d;
    logic        sel_q, sel_d, system_power_monitor_q, system_power_monitor_d, rail_q, rail_d, gate_q, gate_d;
    logic [9:0]  freq_q, freq_d, thr_q, thr_d;
    logic [31:0] deb_target;

    // Pin inputs pass three flops; bit 2 is the stage logic reads
    always_comb begin
        bat_s_d = {bat_s_q[1:0], BATTERY_ABSENT_PIN};
        adp_s_d = {adp_s_q[1:0], ADAPTER_PRESENT};
        one_s_d = {one_s_q[1:0], SINGLE_CELL};
        low_s_d = {low_s_q[1:0], BATTERY_BELOW_SETPOINT};
        cmp_s_d = {cmp_s_q[1:0], COMPARATOR_RAW};
    end

    // Register access; bit 7 is held at zero so a careless host cannot set it
    always_comb begin
        ctrl_d   = ctrl_q;
        rdata_d  = rdata_q;
        rvalid_d = 1'b0;
        if (WR_EN && ADDR == CCR_ADDR_CONTROL_ONE) begin
            ctrl_d = WDATA & CCR_WRITE_MASK;
        end
        if (RD_EN) begin
            rvalid_d = 1'b1;
            if (ADDR == CCR_ADDR_CONTROL_ONE) begin
                rdata_d = ctrl_q;
            end else begin
                rdata_d = 16'h0000;
            end
        end
    end

    // Learn mode
    always_comb begin
        learn_d = learn_q;
        if (!ctrl_q[CCR_LEARN_BIT]) begin
            learn_d = 1'b0;
        // Exit option with a low battery blocks re-entry, else learn mode would toggle every cycle
        end else if (!learn_q && !bat_s_q[2] && !(ctrl_q[CCR_LEARN_EXIT_BIT] && low_s_q[2])) begin
            learn_d = 1'b1;
        end else if (learn_q && ctrl_q[CCR_LEARN_EXIT_BIT] && low_s_q[2]) begin
            learn_d = 1'b0;
        end
    end

    // Comparator debounce: assertion waits, deassertion is immediate
    always_comb begin
        case (ctrl_q[CCR_DEB_MSB:CCR_DEB_LSB])
            2'b00:   deb_target = CCR_DEB0_CYC;
            2'b01:   deb_target = CCR_DEB1_CYC;
            2'b10:   deb_target = DEB2_CYC;
            default: deb_target = DEB3_CYC;
        endcase
        deb_cnt_d = deb_cnt_q;
        cmp_d     = cmp_q;
        if (!cmp_s_q[2]) begin
            deb_cnt_d = 32'h0000_0000;
            cmp_d     = 1'b0;
        end else if (!cmp_q) begin
            if (deb_cnt_q + 32'h0000_0001 >= deb_target) begin
                cmp_d = 1'b1;
            end else begin
                deb_cnt_d = deb_cnt_q + 32'h0000_0001;
            end
        end
    end

    // Decoded modes
    always_comb begin
        rev_d   = ctrl_q[CCR_REVERSE_BIT];
        aud_d   = ctrl_q[CCR_AUDIO_BIT];
        case (ctrl_q[CCR_FREQ_MSB:CCR_FREQ_LSB])
            2'b00:   freq_d = CCR_FREQ_PROGRAM_RESISTOR_PIN;
            2'b01:   freq_d = CCR_FREQ_1;
            2'b10:   freq_d = CCR_FREQ_2;
            default: freq_d = CCR_FREQ_3;
        endcase
        boost_d = !ctrl_q[CCR_BOOST_N_BIT];
        mon_d   = adp_s_q[2] || !ctrl_q[CCR_MON_N_BIT];
        sel_d   = ctrl_q[CCR_MON_SEL_BIT];
        system_power_monitor_d  = ctrl_q[CCR_SYSTEM_POWER_MONITOR_BIT];
        rail_d  = !ctrl_q[CCR_RAIL_N_BIT];
        // Gate is forced on when switching stops; boost-assist drives it too
        gate_d  = ctrl_q[CCR_RAIL_N_BIT] || !ctrl_q[CCR_BOOST_N_BIT];
        if (one_s_q[2]) begin
            thr_d = CCR_THR_1CELL;
        end else begin
            case (ctrl_q[CCR_THR_MSB:CCR_THR_LSB])
                2'b00:   thr_d = CCR_THR_CODE0;
                2'b01:   thr_d = CCR_THR_CODE1;
                2'b10:   thr_d = CCR_THR_CODE2;
                default: thr_d = CCR_THR_CODE3;
            endcase
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ctrl_q    <= CCR_RESET_VALUE;
            rdata_q   <= 16'h0000;
            rvalid_q  <= 1'b0;
            bat_s_q   <= 3'h7;
            adp_s_q   <= 3'h0;
            one_s_q   <= 3'h0;
            low_s_q   <= 3'h0;
            cmp_s_q   <= 3'h0;
            learn_q   <= 1'b0;
            deb_cnt_q <= 32'h0000_0000;
            cmp_q     <= 1'b0;
            rev_q     <= 1'b0;
            aud_q     <= 1'b0;
            freq_q    <= CCR_FREQ_PROGRAM_RESISTOR_PIN;
            boost_q   <= 1'b1;
            mon_q     <= 1'b1;
            sel_q     <= 1'b0;
            system_power_monitor_q    <= 1'b0;
            rail_q    <= 1'b1;
            gate_q    <= 1'b1;
            thr_q     <= CCR_THR_CODE0;
        end else begin
            ctrl_q    <= ctrl_d;
            rdata_q   <= rdata_d;
            rvalid_q  <= rvalid_d;
            bat_s_q   <= bat_s_d;
            adp_s_q   <= adp_s_d;
            one_s_q   <= one_s_d;
            low_s_q   <= low_s_d;
            cmp_s_q   <= cmp_s_d;
            learn_q   <= learn_d;
            deb_cnt_q <= deb_cnt_d;
            cmp_q     <= cmp_d;
            rev_q     <= rev_d;
            aud_q     <= aud_d;
            freq_q    <= freq_d;
            boost_q   <= boost_d;
            mon_q     <= mon_d;
            sel_q     <= sel_d;
            system_power_monitor_q    <= system_power_monitor_d;
            rail_q    <= rail_d;
            gate_q    <= gate_d;
            thr_q     <= thr_d;
        end
    end

    assign RDATA                   = rdata_q;
    assign RVALID                  = rvalid_q;
    assign LEARN_ACTIVE            = learn_q;
    assign REVERSE_POWER_EN        = rev_q;
    assign AUDIO_FILTER_EN         = aud_q;
    assign SWITCH_FREQ_KHZ         = freq_q;
    assign BOOST_ASSIST_EN         = boost_q;
    assign CURRENT_MONITORS_EN     = mon_q;
    assign MONITOR_SELECT_BATTERY  = sel_q;
    assign SYSTEM_POWER_MONITOR_EN = system_power_monitor_q;
    assign RAIL_SWITCHING_EN       = rail_q;
    assign BATTERY_FET_GATE_FORCE  = gate_q;
    assign THROTTLE_THRESHOLD      = thr_q;
    assign COMPARATOR_ASSERTED     = cmp_q;

    property p_write_readback;
        @(posedge CLK) disable iff (RST)
        (WR_EN && ADDR == CCR_ADDR_CONTROL_ONE) ##1 (!WR_EN && !RD_EN)
            ##1 (RD_EN && !WR_EN && ADDR == CCR_ADDR_CONTROL_ONE)
            |=> RDATA == ($past(WDATA, 3) & CCR_WRITE_MASK);
    endproperty
    a_write_readback: assert property (p_write_readback) else $error("readback mismatch");

    property p_bit7_zero;
        @(posedge CLK) disable iff (RST)
        RVALID |-> !RDATA[7];
    endproperty
    a_bit7_zero: assert property (p_bit7_zero) else $error("unused bit read as one");

    property p_learn_needs_battery;
        @(posedge CLK) disable iff (RST)
        $rose(LEARN_ACTIVE) |-> !$past(bat_s_q[2]) && $past(ctrl_q[CCR_LEARN_BIT]);
    endproperty
    a_learn_needs_battery: assert property (p_learn_needs_battery) else $error("learn entered without battery");

    property p_learn_stays;
        @(posedge CLK) disable iff (RST)
        LEARN_ACTIVE && ctrl_q[CCR_LEARN_BIT] && !ctrl_q[CCR_LEARN_EXIT_BIT] |=> LEARN_ACTIVE;
    endproperty
    a_learn_stays: assert property (p_learn_stays) else $error("learn exited while option clear");

    property p_monitor_adapter;
        @(posedge CLK) disable iff (RST)
        adp_s_q[2] |=> CURRENT_MONITORS_EN;
    endproperty
    a_monitor_adapter: assert property (p_monitor_adapter) else $error("monitors off with adapter");

    property p_single_cell;
        @(posedge CLK) disable iff (RST)
        one_s_q[2] |=> THROTTLE_THRESHOLD == CCR_THR_1CELL;
    endproperty
    a_single_cell: assert property (p_single_cell) else $error("single cell threshold wrong");

    property p_rail_gate;
        @(posedge CLK) disable iff (RST)
        ctrl_q[CCR_RAIL_N_BIT] |=> !RAIL_SWITCHING_EN && BATTERY_FET_GATE_FORCE;
    endproperty
    a_rail_gate: assert property (p_rail_gate) else $error("rail disable not applied");

    property p_deb_fast;
        @(posedge CLK) disable iff (RST)
        $rose(COMPARATOR_ASSERTED) |-> $past(ctrl_q[CCR_DEB_MSB]) || $past(deb_cnt_q) + 32'h1 >= CCR_DEB0_CYC;
    endproperty
    a_deb_fast: assert property (p_deb_fast) else $error("comparator asserted early");

    property p_deb_release;
        @(posedge CLK) disable iff (RST)
        !cmp_s_q[2] |=> !COMPARATOR_ASSERTED;
    endproperty
    a_deb_release: assert property (p_deb_release) else $error("comparator held after input fell");

    property p_reverse_follow;
        @(posedge CLK) disable iff (RST)
        REVERSE_POWER_EN == $past(ctrl_q[CCR_REVERSE_BIT]);
    endproperty
    a_reverse_follow: assert property (p_reverse_follow) else $error("reverse power enable wrong");

    property p_audio_follow;
        @(posedge CLK) disable iff (RST)
        AUDIO_FILTER_EN == $past(ctrl_q[CCR_AUDIO_BIT]);
    endproperty
    a_audio_follow: assert property (p_audio_follow) else $error("audio filter enable wrong");

    property p_freq_override;
        @(posedge CLK) disable iff (RST)
        $past(ctrl_q[CCR_FREQ_MSB:CCR_FREQ_LSB]) != 2'h0 |-> SWITCH_FREQ_KHZ != CCR_FREQ_PROGRAM_RESISTOR_PIN;
    endproperty
    a_freq_override: assert property (p_freq_override) else $error("frequency override ignored");

    property p_boost_active_low;
        @(posedge CLK) disable iff (RST)
        BOOST_ASSIST_EN != $past(ctrl_q[CCR_BOOST_N_BIT]);
    endproperty
    a_boost_active_low: assert property (p_boost_active_low) else $error("boost assist polarity wrong");

    property p_boost_gate;
        @(posedge CLK) disable iff (RST)
        BOOST_ASSIST_EN |-> BATTERY_FET_GATE_FORCE;
    endproperty
    a_boost_gate: assert property (p_boost_gate) else $error("gate off with boost assist");

    property p_monitor_battery_only;
        @(posedge CLK) disable iff (RST)
        !$past(adp_s_q[2]) |-> CURRENT_MONITORS_EN != $past(ctrl_q[CCR_MON_N_BIT]);
    endproperty
    a_monitor_battery_only: assert property (p_monitor_battery_only) else $error("monitor disable wrong");

    property p_monitor_select;
        @(posedge CLK) disable iff (RST)
        MONITOR_SELECT_BATTERY == $past(ctrl_q[CCR_MON_SEL_BIT]);
    endproperty
    a_monitor_select: assert property (p_monitor_select) else $error("monitor select wrong");

    property p_system_power_monitor_follow;
        @(posedge CLK) disable iff (RST)
        SYSTEM_POWER_MONITOR_EN == $past(ctrl_q[CCR_SYSTEM_POWER_MONITOR_BIT]);
    endproperty
    a_system_power_monitor_follow: assert property (p_system_power_monitor_follow) else $error("power monitor enable wrong");

    property p_threshold_code;
        @(posedge CLK) disable iff (RST)
        !$past(one_s_q[2]) && $past(ctrl_q[CCR_THR_MSB:CCR_THR_LSB]) == 2'h3 |-> THROTTLE_THRESHOLD == CCR_THR_CODE3;
    endproperty
    a_threshold_code: assert property (p_threshold_code) else $error("throttle threshold wrong");

    property p_unmapped_zero;
        @(posedge CLK) disable iff (RST)
        RD_EN && ADDR != CCR_ADDR_CONTROL_ONE |=> RDATA == 16'h0000;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

    property p_rvalid_pulse;
        @(posedge CLK) disable iff (RST)
        RVALID == $past(RD_EN);
    endproperty
    a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read valid not one cycle after read");
endmodule

// ---- hdl/ccr_pkg.sv ----
// Constants for the charger control-one register block
package ccr_pkg;
    localparam logic [7:0]  CCR_ADDR_CONTROL_ONE = 8'h3c;
    localparam logic [15:0] CCR_RESET_VALUE      = 16'h0000;
    localparam logic [15:0] CCR_WRITE_MASK       = 16'hff7f;
    localparam int          CCR_DEB_MSB          = 15;
    localparam int          CCR_DEB_LSB          = 14;
    localparam int          CCR_LEARN_EXIT_BIT   = 13;
    localparam int          CCR_LEARN_BIT        = 12;
    localparam int          CCR_REVERSE_BIT      = 11;
    localparam int          CCR_AUDIO_BIT        = 10;
    localparam int          CCR_FREQ_MSB         = 9;
    localparam int          CCR_FREQ_LSB         = 8;
    localparam int          CCR_BOOST_N_BIT      = 6;
    localparam int          CCR_MON_N_BIT        = 5;
    localparam int          CCR_MON_SEL_BIT      = 4;
    localparam int          CCR_SYSTEM_POWER_MONITOR_BIT         = 3;
    localparam int          CCR_RAIL_N_BIT       = 2;
    localparam int          CCR_THR_MSB          = 1;
    localparam int          CCR_THR_LSB          = 0;
    // Comparator debounce times in ns, with cycle counts at 100 MHz
    localparam longint      CCR_CLK_PERIOD_NS    = 10;
    localparam longint      CCR_DEB0_NS          = 2000;
    localparam longint      CCR_DEB1_NS          = 12000;
    localparam longint      CCR_DEB2_NS          = 2000000;
    localparam longint      CCR_DEB3_NS          = 64'd5000000000;
    localparam logic [31:0] CCR_DEB0_CYC = 32'((CCR_DEB0_NS + CCR_CLK_PERIOD_NS - 1) / CCR_CLK_PERIOD_NS);
    localparam logic [31:0] CCR_DEB1_CYC = 32'((CCR_DEB1_NS + CCR_CLK_PERIOD_NS - 1) / CCR_CLK_PERIOD_NS);
    localparam logic [31:0] CCR_DEB2_CYC = 32'((CCR_DEB2_NS + CCR_CLK_PERIOD_NS - 1) / CCR_CLK_PERIOD_NS);
    localparam logic [31:0] CCR_DEB3_CYC = 32'((CCR_DEB3_NS + CCR_CLK_PERIOD_NS - 1) / CCR_CLK_PERIOD_NS);
    // Threshold codes in tens of millivolts
    localparam logic [9:0]  CCR_THR_1CELL = 10'd240;
    localparam logic [9:0]  CCR_THR_CODE0 = 10'd600;
    localparam logic [9:0]  CCR_THR_CODE1 = 10'd630;
    localparam logic [9:0]  CCR_THR_CODE2 = 10'd660;
    localparam logic [9:0]  CCR_THR_CODE3 = 10'd690;
    // Switching frequency in kHz, zero means program resistor choice
    localparam logic [9:0]  CCR_FREQ_PROGRAM_RESISTOR_PIN = 10'd0;
    localparam logic [9:0]  CCR_FREQ_1    = 10'd839;
    localparam logic [9:0]  CCR_FREQ_2    = 10'd723;
    localparam logic [9:0]  CCR_FREQ_3    = 10'd635;
endpackage

// ---- sim/ccr_host.sv ----
// Host model that issues control-one register writes and reads
`timescale 1ns/1ps
module ccr_host (
    input  wire logic        clk,
    output logic             wr_en,
    output logic             rd_en,
    output logic [7:0]       addr,
    output logic [15:0]      wdata,
    input  wire logic [15:0] rdata
);
    initial begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr  = 8'h00;
        wdata = 16'h0000;
    end
    // Each access lets an edge pass first, so strobes never toggle twice in one step
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        #1;
        addr  = a;
        wdata = d & 16'hff7f; // Unused bit always written as zero
        wr_en = 1'b1;
        @(posedge clk);
        #1;
        wr_en = 1'b0;
        wdata = ~wdata;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        #1;
        addr  = a;
        rd_en = 1'b1;
        @(posedge clk);
        #1;
        rd_en = 1'b0;
        d     = rdata;
        addr  = ~addr;
    endtask
endmodule

// ---- sim/charger_control_one_register_test.sv ----
// Self-checking bench for the control-one register block
`timescale 1ns/1ps
module charger_control_one_register_test;
    import ccr_pkg::*;
    logic        clk, rst, abs_pin, adapter, single, below, raw;
    logic        rvalid, learn, rev, audio, boost, mons, sel, system_power_monitor, rail, gate, cmp, wr_en, rd_en;
    logic [9:0]  freq, thr;
    logic [7:0]  addr;
    logic [15:0] rdata, wdata, d, v;
    int          n_fail, cmp_count;
    int          seed = 32'h4d98;
    int          tgt [4] = '{200, 1200, 50, 100};

    ccr_control_one #(.DEB2_CYC(32'd50), .DEB3_CYC(32'd100)) u_dut (
        .CLK(clk), .RST(rst), .WR_EN(wr_en), .RD_EN(rd_en), .ADDR(addr), .WDATA(wdata),
        .BATTERY_ABSENT_PIN(abs_pin), .ADAPTER_PRESENT(adapter), .SINGLE_CELL(single),
        .BATTERY_BELOW_SETPOINT(below), .COMPARATOR_RAW(raw), .RDATA(rdata), .RVALID(rvalid),
        .LEARN_ACTIVE(learn), .REVERSE_POWER_EN(rev), .AUDIO_FILTER_EN(audio), .SWITCH_FREQ_KHZ(freq),
        .BOOST_ASSIST_EN(boost), .CURRENT_MONITORS_EN(mons), .MONITOR_SELECT_BATTERY(sel),
        .SYSTEM_POWER_MONITOR_EN(system_power_monitor), .RAIL_SWITCHING_EN(rail), .BATTERY_FET_GATE_FORCE(gate),
        .THROTTLE_THRESHOLD(thr), .COMPARATOR_ASSERTED(cmp));
    ccr_host u_host (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata), .rdata(rdata));

    function automatic logic [9:0] exp_freq(input logic [1:0] c);
        return c == 2'h0 ? CCR_FREQ_PROGRAM_RESISTOR_PIN : c == 2'h1 ? CCR_FREQ_1 : c == 2'h2 ? CCR_FREQ_2 : CCR_FREQ_3;
    endfunction
    function automatic logic [9:0] exp_thr(input logic [1:0] c, input logic s);
        if (s) begin
            return CCR_THR_1CELL;
        end
        return c == 2'h0 ? CCR_THR_CODE0 : c == 2'h1 ? CCR_THR_CODE1 : c == 2'h2 ? CCR_THR_CODE2 : CCR_THR_CODE3;
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk_dec(input logic [15:0] r, input logic ad, input logic sc);
        chk(16'(rev), 16'(r[11]));
        chk(16'(audio), 16'(r[10]));
        chk(16'(freq), 16'(exp_freq(r[9:8])));
        chk(16'(boost), 16'(!r[6]));
        chk(16'(mons), 16'(ad | !r[5]));
        chk(16'(sel), 16'(r[4]));
        chk(16'(system_power_monitor), 16'(r[3]));
        chk(16'(rail), 16'(!r[2]));
        chk(16'(gate), 16'(r[2] | !r[6]));
        chk(16'(thr), 16'(exp_thr(r[1:0], sc)));
    endtask
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #200000;
        n_fail++;
        complete_run();
    end
    initial begin
        rst = 1'b1;
        abs_pin = 1'b0;
        adapter = 1'b0;
        single = 1'b0;
        below = 1'b0;
        raw = 1'b0;
        tick(10);
        rst = 1'b0;
        chk_dec(16'h0000, 1'b0, 1'b0);
        chk(16'(learn), 16'h0000);
        u_host.rd(CCR_ADDR_CONTROL_ONE, d);
        chk(d, CCR_RESET_VALUE);
        // Random words with random adapter and single-cell levels; learn stays off since it keeps history
        for (int i = 0; i < 24; i++) begin
            v = 16'($random(seed));
            v = i == 0 ? 16'hefff : i == 1 ? 16'h0000 : v;
            v[12] = 1'b0;
            adapter = 1'($random(seed));
            single = 1'($random(seed));
            tick(6);
            // Read straight after the write, then again after a write to an unmapped address
            u_host.wr(CCR_ADDR_CONTROL_ONE, v);
            u_host.rd(CCR_ADDR_CONTROL_ONE, d);
            chk(16'(rvalid), 16'h0001);
            chk(d, v & 16'hff7f);
            u_host.wr(8'h3d, ~v);
            u_host.rd(CCR_ADDR_CONTROL_ONE, d);
            chk(d, v & 16'hff7f);
            chk_dec(v, adapter, single);
            chk(16'(learn), 16'h0000);
        end
        u_host.rd(8'h3d, d);
        chk(d, 16'h0000);
        abs_pin = 1'b1;
        tick(6);
        u_host.wr(CCR_ADDR_CONTROL_ONE, 16'h3000);
        tick(6);
        chk(16'(learn), 16'h0000);
        abs_pin = 1'b0;
        tick(6);
        chk(16'(learn), 16'h0001);
        below = 1'b1;
        tick(6);
        chk(16'(learn), 16'h0000);
        u_host.wr(CCR_ADDR_CONTROL_ONE, 16'h1000);
        tick(6);
        chk(16'(learn), 16'h0001);
        u_host.wr(CCR_ADDR_CONTROL_ONE, 16'h0000);
        tick(2);
        chk(16'(learn), 16'h0000);
        // Debounce per code; the slow codes run with shortened parameter counts
        for (int k = 0; k < 4; k++) begin
            u_host.wr(CCR_ADDR_CONTROL_ONE, 16'(k) << 14);
            tick(2);
            raw = 1'b1;
            tick(tgt[k] - 1);
            chk(16'(cmp), 16'h0000);
            tick(12);
            chk(16'(cmp), 16'h0001);
            raw = 1'b0;
            tick(6);
            chk(16'(cmp), 16'h0000);
        end
        // A reset in mid-run must drop a written word back to zero
        u_host.wr(CCR_ADDR_CONTROL_ONE, 16'hff7f);
        tick(2);
        chk(16'(rail), 16'h0000);
        rst = 1'b1;
        tick(2);
        rst = 1'b0;
        chk_dec(16'h0000, 1'b0, 1'b0);
        u_host.rd(CCR_ADDR_CONTROL_ONE, d);
        chk(d, CCR_RESET_VALUE);
        tick(1);
        chk(16'(rvalid), 16'h0000);
        complete_run();
    end
endmodule
